// File: hw/tpc_timer.sv
/*
  16-bit timer with three compare/capture channels, PWM and channel 2/3
  buffered pairing, registers on Avalon-MM with one wait state.
  Assumes pins and bus are synchronous to sys_clk_i.
*/
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module tpc_timer
  import tpc_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic [`TPC_AW-1:0]   avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  input  wire logic [3:0]           avs_byteenable_i,
  output logic      [31:0]          avs_readdata_o,
  output logic                      avs_waitrequest_o,
  input  wire logic [`TPC_NCH-1:0]  ch_pin_i,
  output logic      [`TPC_NCH-1:0]  ch_pin_o,
  output logic      [`TPC_NCH-1:0]  ch_pin_oe_o,
  output logic      [`TPC_NCH-1:0]  chan_irq_o
);
  import tpc_pkg::*;

  tpc_state_t st_ff;
  tpc_state_t nxt_st;
  logic       req;
  logic       wr_acc;
  logic       rd_acc;
  logic       tick;
  logic       ovf;
  logic       paired;
  logic [2:0] match_c;
  logic [2:0] event_c;
  logic [6:0] mask;
  logic [7:0] wb;

  function automatic logic [`TPC_AW-1:0] ch_addr(input logic [1:0] i,
                                                 input logic [1:0] k);
    ch_addr = `TPC_OFS_CH_BASE + `TPC_CH_STRIDE * {4'h0, i}
              + {2'h0, k, 2'h0};
  endfunction : ch_addr

  function automatic logic [7:0] reg_read(input tpc_state_t s,
                                          input logic [`TPC_AW-1:0] a);
    reg_read = 8'h00;
    if (a == `TPC_OFS_MAIN)
      reg_read = {2'h0, s.halt, 2'h0, s.ps};
    if (a == `TPC_OFS_CNT_H)
      reg_read = s.cnt[15:8];
    if (a == `TPC_OFS_CNT_L)
      reg_read = s.cnt[7:0];
    if (a == `TPC_OFS_MOD_H)
      reg_read = s.modv[15:8];
    if (a == `TPC_OFS_MOD_L)
      reg_read = s.modv[7:0];
    for (int i = 0; i < `TPC_NCH; i++)
    begin
      if (a == ch_addr(2'(i), `TPC_K_CTRL))
        reg_read = s.csc[i];
      if (a == ch_addr(2'(i), `TPC_K_VAL_H))
        reg_read = s.val[i][15:8];
      if (a == ch_addr(2'(i), `TPC_K_VAL_L))
        reg_read = s.val[i][7:0];
    end
  endfunction : reg_read

  // One wait state: read data is registered before the answer
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~st_ff.ack;
  assign avs_readdata_o    = {24'h0, st_ff.rdata};
  assign wr_acc = avs_write_i & st_ff.ack & avs_byteenable_i[0];
  assign rd_acc = avs_read_i & st_ff.ack;
  assign wb     = avs_writedata_i[7:0];
  assign paired = st_ff.csc[1][`TPC_BIT_MODE_HI];
  assign mask   = 7'((8'h01 << st_ff.ps) - 8'h01);

  always_comb
  begin
    logic [1:0]  mode;
    logic [1:0]  els;
    logic [15:0] cval;
    logic        edge_hit;
    logic        dead;
    mode     = 2'h0;
    els      = 2'h0;
    cval     = 16'h0000;
    edge_hit = 1'b0;
    dead     = 1'b0;
    nxt_st   = st_ff;
    nxt_st.ack   = req & ~st_ff.ack;
    nxt_st.pin_d = ch_pin_i;
    if (req & ~st_ff.ack)
      nxt_st.rdata = reg_read(st_ff, avs_address_i);
    tick = ~st_ff.halt && ((st_ff.div & mask) == mask);
    ovf  = tick && (st_ff.cnt == st_ff.modv);
    if (~st_ff.halt)
      nxt_st.div = st_ff.div + 7'h01;
    if (ovf)
      nxt_st.cnt = 16'h0000;
    else if (tick)
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    if (ovf)
      nxt_st.act3 = paired & st_ff.last3;
    if (~paired)
      nxt_st.act3 = 1'b0;
    ch_pin_oe_o = 3'h0;
    chan_irq_o  = 3'h0;
    match_c     = 3'h0;
    event_c     = 3'h0;
    for (int i = 0; i < `TPC_NCH; i++)
    begin
      mode = st_ff.csc[i][`TPC_BIT_MODE_HI:`TPC_BIT_MODE_LO];
      els  = st_ff.csc[i][`TPC_BIT_ELS_HI:`TPC_BIT_ELS_LO];
      dead = (i == 2) && paired;
      cval = (i == 1 && st_ff.act3) ? st_ff.val[2] : st_ff.val[i];
      match_c[i] = tick && mode != 2'h0 && st_ff.cnt == cval && !dead;
      edge_hit = mode == 2'h0 && !dead &&
        ((els[0] && ch_pin_i[i] && !st_ff.pin_d[i]) ||
         (els[1] && !ch_pin_i[i] && st_ff.pin_d[i]));
      event_c[i] = match_c[i] | edge_hit;
      if (edge_hit)
        nxt_st.val[i] = st_ff.cnt;
      ch_pin_oe_o[i] = mode != 2'h0 && els != 2'h0 && !dead;
      if (ovf && st_ff.csc[i][`TPC_BIT_TOV])
        nxt_st.pin[i] = ~st_ff.pin[i];
      if (match_c[i])
      begin
        if (els == `TPC_ELS_TOGGLE)
          nxt_st.pin[i] = ~st_ff.pin[i];
        else if (els == `TPC_ELS_CLEAR)
          nxt_st.pin[i] = 1'b0;
        else if (els == `TPC_ELS_SET)
          nxt_st.pin[i] = 1'b1;
      end
      // Full duty parks the pin at the pulse level, match ignored
      if (st_ff.csc[i][`TPC_BIT_FULL] && st_ff.csc[i][`TPC_BIT_TOV])
        nxt_st.pin[i] = (els == `TPC_ELS_CLEAR);
      if (wr_acc && avs_address_i == ch_addr(2'(i), `TPC_K_CTRL))
      begin
        nxt_st.csc[i][6:0] = wb[6:0];
        if (i != 1)
          nxt_st.csc[i][`TPC_BIT_MODE_HI] = 1'b0;
        if (!wb[`TPC_BIT_FLAG] && st_ff.arm[i])
        begin
          nxt_st.csc[i][`TPC_BIT_FLAG] = 1'b0;
          nxt_st.arm[i] = 1'b0;
        end
      end
      if (rd_acc && avs_address_i == ch_addr(2'(i), `TPC_K_CTRL) &&
          st_ff.csc[i][`TPC_BIT_FLAG])
        nxt_st.arm[i] = 1'b1;
      // Set beats clear; a fresh event also voids a pending clear
      if (event_c[i])
      begin
        nxt_st.csc[i][`TPC_BIT_FLAG] = 1'b1;
        nxt_st.arm[i] = 1'b0;
      end
      if (wr_acc && avs_address_i == ch_addr(2'(i), `TPC_K_VAL_H))
        nxt_st.val[i][15:8] = wb;
      if (wr_acc && avs_address_i == ch_addr(2'(i), `TPC_K_VAL_L))
        nxt_st.val[i][7:0] = wb;
      if (wr_acc && (avs_address_i == ch_addr(2'(i), `TPC_K_VAL_H) ||
                     avs_address_i == ch_addr(2'(i), `TPC_K_VAL_L)) &&
          i != 0)
        nxt_st.last3 = (i == 2);
      chan_irq_o[i] = st_ff.csc[i][`TPC_BIT_FLAG] &
                      st_ff.csc[i][`TPC_BIT_IE];
    end
    if (wr_acc && avs_address_i == `TPC_OFS_MAIN)
    begin
      nxt_st.halt = wb[`TPC_MAIN_HALT];
      nxt_st.ps   = wb[2:0];
      if (wb[`TPC_MAIN_CLEAR])
      begin
        nxt_st.cnt = 16'h0000;
        nxt_st.div = 7'h00;
      end
    end
    if (wr_acc && avs_address_i == `TPC_OFS_MOD_H)
      nxt_st.modv[15:8] = wb;
    if (wr_acc && avs_address_i == `TPC_OFS_MOD_L)
      nxt_st.modv[7:0] = wb;
  end

  assign ch_pin_o = st_ff.pin;

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_ff       <= '0;
      st_ff.halt  <= `TPC_HALT_RST;
      st_ff.ps    <= `TPC_MAIN_RST;
      st_ff.modv  <= `TPC_MOD_RST;
    end
    else
      st_ff <= nxt_st;
  end

  property p_wait_one;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (req && avs_waitrequest_o) |=> (req -> !avs_waitrequest_o);
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest not released after one cycle");
  property p_cmp_flag;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (tick && st_ff.csc[0][5:4] == `TPC_MODE_UNBUF &&
       st_ff.cnt == st_ff.val[0]) |=> st_ff.csc[0][`TPC_BIT_FLAG];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag)
    else $error("compare match did not set flag");
  property p_no_arm_keep;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (st_ff.csc[0][`TPC_BIT_FLAG] && !st_ff.arm[0])
        |=> st_ff.csc[0][`TPC_BIT_FLAG];
  endproperty
  a_no_arm_keep: assert property (p_no_arm_keep)
    else $error("flag cleared without prior read");
  property p_one_keeps;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (!st_ff.csc[2][`TPC_BIT_FLAG] && !event_c[2])
        |=> !st_ff.csc[2][`TPC_BIT_FLAG];
  endproperty
  a_one_keeps: assert property (p_one_keeps)
    else $error("flag set without event");
  property p_event_wins;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      event_c[1] |=> st_ff.csc[1][`TPC_BIT_FLAG] && !st_ff.arm[1];
  endproperty
  a_event_wins: assert property (p_event_wins)
    else $error("event lost against clear");
  property p_irq_mask;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !st_ff.csc[0][`TPC_BIT_IE] |-> !chan_irq_o[0];
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt not blocked");
  property p_wrap;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (ovf && !wr_acc) |=> st_ff.cnt == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap at modulo");
  property p_halt;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (st_ff.halt && !wr_acc) |=> $stable(st_ff.cnt);
  endproperty
  a_halt: assert property (p_halt)
    else $error("counter moved while halted");
  property p_pair_pin;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      paired |-> !ch_pin_oe_o[2] && !event_c[2];
  endproperty
  a_pair_pin: assert property (p_pair_pin)
    else $error("channel 3 active while paired");
  property p_clr_out;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (match_c[0] && st_ff.csc[0][3:2] == `TPC_ELS_CLEAR &&
       !st_ff.csc[0][`TPC_BIT_FULL]) |=> !ch_pin_o[0];
  endproperty
  a_clr_out: assert property (p_clr_out)
    else $error("match did not clear output");
endmodule : tpc_timer

// File: shared/tpc_cfg.svh
/*
  Offsets, field positions, reset values and counts for the timer channel
  PWM block. Assumes byte addresses on a 32-bit Avalon-MM register bus.
*/
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH
`define TPC_AW           6
`define TPC_NCH          3
`define TPC_OFS_MAIN     6'h00
`define TPC_OFS_CNT_H    6'h04
`define TPC_OFS_CNT_L    6'h08
`define TPC_OFS_MOD_H    6'h0c
`define TPC_OFS_MOD_L    6'h10
`define TPC_OFS_CH_BASE  6'h14
`define TPC_CH_STRIDE    6'h0c
`define TPC_K_CTRL       2'h0
`define TPC_K_VAL_H      2'h1
`define TPC_K_VAL_L      2'h2
`define TPC_MAIN_HALT    5
`define TPC_MAIN_CLEAR   4
`define TPC_BIT_FLAG     7
`define TPC_BIT_IE       6
`define TPC_BIT_MODE_HI  5
`define TPC_BIT_MODE_LO  4
`define TPC_BIT_ELS_HI   3
`define TPC_BIT_ELS_LO   2
`define TPC_BIT_TOV      1
`define TPC_BIT_FULL     0
`define TPC_MODE_UNBUF   2'h1
`define TPC_MODE_BUF     2'h2
`define TPC_ELS_TOGGLE   2'h1
`define TPC_ELS_CLEAR    2'h2
`define TPC_ELS_SET      2'h3
`define TPC_MAIN_RST     3'h0
`define TPC_HALT_RST     1'h1
`define TPC_CSC_RST      8'h00
`define TPC_MOD_RST      16'hffff
`define TPC_VAL_RST      16'h0000
`endif

// File: shared/tpc_pkg.sv
/*
  Types for the timer channel PWM block.
  Widths are literals; the three channels match TPC_NCH in tpc_cfg.svh.
*/
package tpc_pkg;
  typedef struct packed {
    logic             ack;
    logic [7:0]       rdata;
    logic             halt;
    logic [2:0]       ps;
    logic [6:0]       div;
    logic [15:0]      cnt;
    logic [15:0]      modv;
    logic [2:0][7:0]  csc;
    logic [2:0][15:0] val;
    logic [2:0]       arm;
    logic [2:0]       pin;
    logic [2:0]       pin_d;
    logic             last3;
    logic             act3;
  } tpc_state_t;
endpackage : tpc_pkg

// File: test/tpc_load.sv
/*
  Load on the three channel pins: weak pull-down plus an optional
  external driver. Assumes the timer drives a pin only while oe is high.
*/
`timescale 1ns/1ps
module tpc_load
(
  input  wire logic [2:0] pin_o_i,
  input  wire logic [2:0] pin_oe_i,
  input  wire logic [2:0] ext_en_i,
  input  wire logic [2:0] ext_lvl_i,
  output logic      [2:0] level_o
);
  // Released pins follow the external driver if enabled, else fall to the pull-down, never keep the last level
  always_comb
    for (int i = 0; i < 3; i++)
      level_o[i] = pin_oe_i[i] ? pin_o_i[i] :
                   (ext_en_i[i] ? ext_lvl_i[i] : 1'b0);
endmodule : tpc_load

// File: test/tpc_timer_tb.sv
/*
  Self-checking bench for tpc_timer: bus tasks, one task per scenario.
  Assumes one wait state on the bus and prescale 0 (tick every cycle) except for the prescale-by-2 step in test_pwm.
*/
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module tpc_timer_tb;
  logic        sys_clk_i, resetn_i, rd, wr;
  logic [5:0]  addr;
  logic [31:0] wd, rdata;
  logic [3:0]  be;
  logic        wreq;
  logic [2:0]  pin_i, pin_o, oe, irq, ext_en, ext_lvl;
  logic [7:0]  q;
  int          fails, num_checks;

  tpc_timer dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .ch_pin_i(pin_i), .ch_pin_o(pin_o), .ch_pin_oe_o(oe),
    .chan_irq_o(irq));
  tpc_load load (.pin_o_i(pin_o), .pin_oe_i(oe), .ext_en_i(ext_en),
    .ext_lvl_i(ext_lvl), .level_o(pin_i));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %0h", $time, m, got);
    end
  endtask : chk

  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    addr <= a;
    wr <= w;
    rd <= ~w;
    wd <= {24'h0, d};
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata[7:0];
    chk(32'(n < 20), 1, "bus answer");
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus

  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e, "read");
  endtask : rdc

  function automatic logic [5:0] ca(input int c, input int k);
    return `TPC_OFS_CH_BASE + 6'(c) * `TPC_CH_STRIDE + 6'(4 * k);
  endfunction : ca

  // High cycles over 100 cycles, ten whole periods of 10 at prescale 0
  task automatic duty(input int c, input int e);
    int h;
    h = 0;
    repeat (100)
    begin
      @(posedge sys_clk_i);
      if (pin_i[c] === 1'b1)
        h++;
    end
    chk(h, e, "duty");
  endtask : duty

  task automatic pwm(input int c, input logic [7:0] ctl);
    bus(1'b1, `TPC_OFS_MAIN, 8'h30);
    bus(1'b1, `TPC_OFS_MOD_H, 8'h00);
    bus(1'b1, `TPC_OFS_MOD_L, 8'h09);
    bus(1'b1, ca(c, 1), 8'h00);
    bus(1'b1, ca(c, 2), 8'h03);
    bus(1'b1, ca(c, 0), ctl);
    bus(1'b1, `TPC_OFS_MAIN, 8'h00);
    repeat (20) @(posedge sys_clk_i);
  endtask : pwm

  task automatic test_regs();
    rdc(`TPC_OFS_MAIN, 8'h20);
    rdc(`TPC_OFS_MOD_H, 8'hff);
    rdc(ca(0, 0), 8'h00);
    rdc(ca(0, 2), 8'h00);
    rdc(6'h3c, 8'h00);
    be <= 4'h0;
    bus(1'b1, `TPC_OFS_MOD_L, 8'h12);
    be <= 4'h1;
    rdc(`TPC_OFS_MOD_L, 8'hff);
    bus(1'b1, `TPC_OFS_CNT_L, 8'h55);
    rdc(`TPC_OFS_CNT_L, 8'h00);
    bus(1'b1, ca(0, 0), 8'h20);
    rdc(ca(0, 0), 8'h00);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_pwm();
    pwm(0, 8'h5a);
    duty(0, 40);
    chk(oe[0], 1'b1, "oe");
    pwm(0, 8'h5e);
    duty(0, 60);
    chk(irq[0], 1'b1, "irq");
    // Toggle on match: pin period doubles, half duty
    bus(1'b1, ca(0, 0), 8'h54);
    repeat (20) @(posedge sys_clk_i);
    duty(0, 50);
    // Prescale by 2 doubles the period, duty unchanged
    bus(1'b1, ca(0, 0), 8'h5e);
    bus(1'b1, `TPC_OFS_MAIN, 8'h01);
    repeat (40) @(posedge sys_clk_i);
    duty(0, 60);
    // Full duty parks the pin low for the set action
    bus(1'b1, ca(0, 0), 8'h5f);
    repeat (2) @(posedge sys_clk_i);
    duty(0, 0);
    $display("test_pwm done");
  endtask : test_pwm

  task automatic test_flag();
    bus(1'b1, `TPC_OFS_MAIN, 8'h20);
    bus(1'b1, ca(0, 0), 8'h5e);
    rdc(ca(0, 0), 8'hde);
    bus(1'b1, ca(0, 0), 8'hde);
    rdc(ca(0, 0), 8'hde);
    bus(1'b1, ca(0, 0), 8'h5e);
    chk(irq[0], 1'b0, "irq clr");
    rdc(ca(0, 0), 8'h5e);
    bus(1'b1, `TPC_OFS_MAIN, 8'h00);
    repeat (30) @(posedge sys_clk_i);
    rdc(ca(0, 0), 8'hde);
    repeat (12) @(posedge sys_clk_i);
    bus(1'b1, `TPC_OFS_MAIN, 8'h20);
    bus(1'b1, ca(0, 0), 8'h5e);
    rdc(ca(0, 0), 8'hde);
    bus(1'b1, ca(0, 0), 8'h9e);
    chk(irq[0], 1'b0, "irq mask");
    $display("test_flag done");
  endtask : test_flag

  task automatic test_capture();
    bus(1'b1, ca(2, 0), 8'h04);
    ext_en[2] <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    ext_lvl[2] <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rdc(ca(2, 0), 8'h84);
    chk(oe[2], 1'b0, "oe cap");
    // Counter is halted, so the captured value equals it
    bus(1'b0, `TPC_OFS_CNT_L, 8'h00);
    rdc(ca(2, 2), q);
    bus(1'b1, ca(2, 0), 8'h08);
    rdc(ca(2, 0), 8'h08);
    ext_en[2] <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rdc(ca(2, 0), 8'h88);
    $display("test_capture done");
  endtask : test_capture

  task automatic test_pair();
    pwm(1, 8'h2a);
    duty(1, 40);
    chk(oe, 3'b011, "oe pair");
    bus(1'b1, ca(2, 1), 8'h00);
    bus(1'b1, ca(2, 2), 8'h06);
    repeat (20) @(posedge sys_clk_i);
    duty(1, 70);
    $display("test_pair done");
  endtask : test_pair

  // Reset in mid-run must bring back the reset values
  task automatic test_reset();
    resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    chk(oe, 3'b000, "oe reset");
    chk(pin_o, 3'b000, "pin reset");
    rdc(`TPC_OFS_MAIN, 8'h20);
    rdc(ca(1, 0), 8'h00);
    rdc(`TPC_OFS_MOD_L, 8'hff);
    $display("test_reset done");
  endtask : test_reset

  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // Scenarios need about 1100 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    end_sim();
  end

  initial
  begin
    resetn_i = 1'b0;
    {rd, wr, addr, wd, ext_en, ext_lvl} = '0;
    be = 4'h1;
    fails = 0;
    num_checks = 0;
    repeat (12) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    test_regs();
    test_pwm();
    test_flag();
    test_capture();
    test_pair();
    test_reset();
    end_sim();
  end
endmodule : tpc_timer_tb
